// File: rtl/eag_map.svh
// Constants and field positions for the effective address generator
// Summary of operation
// - Eleven modes: register, immediate, nine memory
// - Register operand at byte, word, dword
// - Immediate operand taken from instruction bytes
// - Linear address is segment base plus offset
// - Displacement is none, 8, 16 or 32 bits
// - Any general register may be base
// - Stack pointer never selectable as index
// - Index scaled by 1, 2, 4, 8
// - Offset is base plus scaled index plus displacement
// - Address forming pipelined, usually no extra cycles
// - Base with index costs one extra cycle
// - Direct mode offset is displacement only
// - Register indirect offset is base alone
// - Based offset is base plus displacement
// - Index offset is index plus displacement, unscaled
// - Scaled index offset is scaled index plus displacement
// - Based index offset is base plus index
// - Based scaled index is base plus scaled index
// - Based index displacement sums all three
// - Based scaled index displacement sums all three
// - Real mode base is selector shifted four
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH
`define EAG_DATA_W 32
`define EAG_NUM_REGS 8
`define EAG_SP_IDX 3'h4
`define EAG_SEG_SHIFT 4
`define EAG_SCALE_MAX 2'h3
`define EAG_EXTRA_CYCLES 1
`define EAG_RESET_ADDR 32'h0000_0000
`endif

// File: rtl/eag_pkg.sv
// Types for the effective address generator
package eag_pkg;
   typedef enum logic [3:0] {
      EAG_REG, EAG_IMM, EAG_DIRECT, EAG_REG_IND, EAG_BASED, EAG_INDEX,
      EAG_SC_INDEX, EAG_B_INDEX, EAG_B_SC_INDEX, EAG_B_INDEX_D,
      EAG_B_SC_INDEX_D
   } eag_mode_t;
   typedef enum logic [1:0] {EAG_W8, EAG_W16, EAG_W32} eag_width_t;
   typedef enum logic [1:0] {EAG_D0, EAG_D8, EAG_D16, EAG_D32} eag_dsz_t;
   typedef struct packed {
      eag_mode_t mode;
      eag_width_t width;
      logic [2:0] base_sel;
      logic [2:0] index_sel;
      logic [1:0] scale;
      eag_dsz_t dsz;
      logic [31:0] disp;
      logic [31:0] imm;
      logic [15:0] selector;
      logic [31:0] seg_base;
      logic real_mode;
   } eag_req_t;
   typedef struct packed {
      logic is_mem;
      logic [31:0] operand;
      logic [31:0] offset;
      logic [31:0] linear;
   } eag_res_t;
endpackage

// File: rtl/eag_scaler.sv
// Index scaling shifter
`timescale 1ns/1ps
`include "eag_map.svh"
module eag_scaler import eag_pkg::*; #(
   parameter int W = `EAG_DATA_W
) (
   input wire logic [W-1:0] index_val,
   input wire logic [1:0] scale,
   output logic [W-1:0] scaled
);
   // A word this narrow would lose the whole shifted index
   if (W < 4) begin : g_w_chk
      $error("eag_scaler: W must be at least 4");
   end

   // Shift of 0 to 3 bits, upper bits drop for modulo wrap
   always_comb begin
      scaled = index_val << scale;
   end
endmodule // eag_scaler

// File: rtl/eag_disp_ext.sv
// Displacement sign extension
`timescale 1ns/1ps
`include "eag_map.svh"
module eag_disp_ext import eag_pkg::*; (
   input wire logic [31:0] disp_raw,
   input eag_dsz_t dsz,
   output logic [31:0] disp
);
   // Narrow displacements are signed and widen before the add
   always_comb begin
      unique case (dsz)
         EAG_D0: disp = 32'h0000_0000;
         EAG_D8: disp = {{24{disp_raw[7]}}, disp_raw[7:0]};
         EAG_D16: disp = {{16{disp_raw[15]}}, disp_raw[15:0]};
         EAG_D32: disp = disp_raw;
      endcase
   end
endmodule // eag_disp_ext

// File: rtl/eag_top.sv
// Effective and linear address generator datapath
`timescale 1ns/1ps
`include "eag_map.svh"
module eag_top import eag_pkg::*; #(
   parameter int NUM_REGS = `EAG_NUM_REGS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input eag_req_t req,
   input wire logic [NUM_REGS*32-1:0] gpr_flat,
   output logic res_valid,
   output eag_res_t res,
   output logic index_err
);
   // Register file indexing assumes the eight-entry encoding
   if (NUM_REGS != `EAG_NUM_REGS) begin : g_regs_chk
      $error("eag_top: NUM_REGS must be 8");
   end

   typedef enum {ST_IDLE, ST_ADD2} eag_st_t;
   eag_st_t st_ff;

   logic [31:0] gpr [NUM_REGS];
   eag_req_t hold_ff;
   logic [31:0] part_ff;
   logic [31:0] disp_x;
   logic [31:0] scaled;
   logic [31:0] base_v;
   logic [31:0] idx_v;
   logic [31:0] sum_bi;
   logic [31:0] nxt_off;
   logic [31:0] nxt_operand;
   logic nxt_mem;
   logic two_step;
   logic take;
   logic use_scale;
   eag_res_t res_ff;
   logic res_valid_ff;
   logic index_err_ff;

   // Unpack the flat register file bus
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g = g + 1) begin : g_unpack
         assign gpr[g] = gpr_flat[g*32 +: 32];
      end
   endgenerate

   // Mode decode shared by several decisions
   function automatic logic needs_both(eag_mode_t m);
      return m inside {EAG_B_INDEX, EAG_B_SC_INDEX, EAG_B_INDEX_D,
                       EAG_B_SC_INDEX_D};
   endfunction

   function automatic logic is_scaled(eag_mode_t m);
      return m inside {EAG_SC_INDEX, EAG_B_SC_INDEX, EAG_B_SC_INDEX_D};
   endfunction

   function automatic logic [31:0] width_cut(logic [31:0] v, eag_width_t w);
      unique case (w)
         EAG_W8: return {24'h00_0000, v[7:0]};
         EAG_W16: return {16'h0000, v[15:0]};
         default: return v;
      endcase
   endfunction

   function automatic logic [31:0] seg_of(eag_req_t r);
      if (r.real_mode) begin
         return {12'h000, r.selector, 4'h0};
      end
      return r.seg_base;
   endfunction

   eag_disp_ext u_disp (
      .disp_raw (req.disp),
      .dsz (req.dsz),
      .disp (disp_x)
   );

   assign use_scale = is_scaled(req.mode);

   eag_scaler #(.W(32)) u_scale (
      .index_val (idx_v),
      .scale (use_scale ? req.scale : 2'h0),
      .scaled (scaled)
   );

   // Any register may serve as base
   assign base_v = gpr[req.base_sel];
   // Stack pointer forced to zero as index
   assign idx_v = (req.index_sel == `EAG_SP_IDX) ? 32'h0000_0000 :
                  gpr[req.index_sel];
   assign sum_bi = base_v + scaled;

   // Only idle state accepts, the extra add blocks the next request
   assign req_ready = (st_ff == ST_IDLE);
   assign take = req_valid && req_ready;
   assign two_step = needs_both(req.mode);

   // Single-cycle offset and operand forming per mode
   always_comb begin
      nxt_off = 32'h0000_0000;
      nxt_operand = 32'h0000_0000;
      nxt_mem = 1'b1;
      unique case (req.mode)
         EAG_REG: begin
            nxt_mem = 1'b0;
            nxt_operand = width_cut(gpr[req.base_sel], req.width);
         end
         EAG_IMM: begin
            nxt_mem = 1'b0;
            nxt_operand = width_cut(req.imm, req.width);
         end
         EAG_DIRECT: nxt_off = disp_x;
         EAG_REG_IND: nxt_off = base_v;
         EAG_BASED: nxt_off = base_v + disp_x;
         EAG_INDEX: nxt_off = idx_v + disp_x;
         EAG_SC_INDEX: nxt_off = scaled + disp_x;
         EAG_B_INDEX, EAG_B_SC_INDEX,
         EAG_B_INDEX_D, EAG_B_SC_INDEX_D: nxt_off = sum_bi;
         default: nxt_mem = 1'b0;
      endcase
   end

   // Sequencer: second cycle adds displacement for EAG_B_INDEX_D and EAG_B_SC_INDEX_D
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE: if (take && two_step) st_ff <= ST_ADD2;
            ST_ADD2: st_ff <= ST_IDLE;
         endcase
      end
   end

   // Partial sum and request held across the extra cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_ff <= '0;
         part_ff <= `EAG_RESET_ADDR;
      end else if (take) begin
         hold_ff <= req;
         hold_ff.disp <= disp_x;
         part_ff <= sum_bi;
      end
   end

   // Result register, wrap by 32-bit adds
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_ff <= '0;
         res_valid_ff <= 1'b0;
      end else begin
         res_valid_ff <= 1'b0;
         if (st_ff == ST_ADD2) begin
            res_valid_ff <= 1'b1;
            res_ff.is_mem <= 1'b1;
            res_ff.operand <= 32'h0000_0000;
            if (hold_ff.mode inside {EAG_B_INDEX_D, EAG_B_SC_INDEX_D}) begin
               res_ff.offset <= part_ff + hold_ff.disp;
               res_ff.linear <= part_ff + hold_ff.disp +
                                seg_of(hold_ff);
            end else begin
               res_ff.offset <= part_ff;
               res_ff.linear <= part_ff + seg_of(hold_ff);
            end
         end else if (take && !two_step) begin
            // Pipelined single cycle path
            res_valid_ff <= 1'b1;
            res_ff.is_mem <= nxt_mem;
            res_ff.operand <= nxt_operand;
            res_ff.offset <= nxt_mem ? nxt_off : 32'h0000_0000;
            res_ff.linear <= nxt_mem ? nxt_off + seg_of(req) :
                             32'h0000_0000;
         end
      end
   end

   // Flags a request that named the stack pointer as index
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         index_err_ff <= 1'b0;
      end else begin
         index_err_ff <= take && req.index_sel == `EAG_SP_IDX &&
                         (req.mode inside {EAG_INDEX, EAG_SC_INDEX} ||
                          two_step);
      end
   end

   assign res_valid = res_valid_ff;
   assign res = res_ff;
   assign index_err = index_err_ff;

   // Checks: single-cycle modes answer on the next edge
   one_cycle_a: assert property (@(posedge clk) disable iff (rst)
      take && !two_step |=> res_valid)
      else $error("single step result late");

   // Base with index holds the answer back exactly one edge
   extra_clk_a: assert property (@(posedge clk) disable iff (rst)
      take && two_step |=> !res_valid ##1 res_valid)
      else $error("base index result timing wrong");

   // Next request must wait while the second add runs
   stall_a: assert property (@(posedge clk) disable iff (rst)
      take && two_step |=> !req_ready)
      else $error("ready not dropped in extra cycle");

   // Ready returns right after the extra cycle, no longer stall
   ready_back_a: assert property (@(posedge clk) disable iff (rst)
      st_ff == ST_ADD2 |=> req_ready)
      else $error("ready not restored after extra cycle");

   // Result strobe only ever follows an accepted request
   valid_pulse_a: assert property (@(posedge clk) disable iff (rst)
      !take && st_ff != ST_ADD2 |=> !res_valid)
      else $error("result strobe without request");

   // Direct offset is the widened displacement alone
   direct_off_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_DIRECT |=> res.offset == $past(disp_x))
      else $error("direct offset wrong");

   // Register indirect passes the base through untouched
   indir_off_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_REG_IND |=> res.offset == $past(base_v))
      else $error("indirect offset wrong");

   // Based offset rebuilt from the register file, not the shared adder
   based_off_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_BASED |=>
      res.offset == $past(gpr[req.base_sel] + disp_x))
      else $error("based offset wrong");

   // Index mode ignores the scale field
   index_off_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_INDEX && req.index_sel != `EAG_SP_IDX |=>
      res.offset == $past(gpr[req.index_sel] + disp_x))
      else $error("index offset wrong");

   // Scaled index, shift taken straight from the request
   sc_index_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_SC_INDEX && req.index_sel != `EAG_SP_IDX |=>
      res.offset == $past((gpr[req.index_sel] << req.scale) + disp_x))
      else $error("scaled index offset wrong");

   // Base plus index drops any supplied displacement
   b_index_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_B_INDEX && req.index_sel != `EAG_SP_IDX
      |-> ##2 res.offset ==
      $past(gpr[req.base_sel] + gpr[req.index_sel], 2))
      else $error("base index offset wrong");

   // Base plus scaled index, also without displacement
   b_sc_index_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_B_SC_INDEX && req.index_sel != `EAG_SP_IDX
      |-> ##2 res.offset ==
      $past(gpr[req.base_sel] + (gpr[req.index_sel] << req.scale), 2))
      else $error("base scaled index offset wrong");

   // All three terms, index unscaled
   b_index_d_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_B_INDEX_D && req.index_sel != `EAG_SP_IDX
      |-> ##2 res.offset ==
      $past(gpr[req.base_sel] + gpr[req.index_sel] + disp_x, 2))
      else $error("base index displacement offset wrong");

   // All three terms with the index scaled
   full_sum_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_B_SC_INDEX_D |-> ##2
      res.offset == $past(sum_bi + disp_x, 2))
      else $error("full sum wrong");

   // Short displacement must carry its sign into the upper bits
   disp8_ext_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_BASED && req.dsz == EAG_D8 |=>
      res.offset == $past(base_v + {{24{req.disp[7]}}, req.disp[7:0]}))
      else $error("short displacement not sign extended");

   // Linear address on the single-cycle path
   linear_sum_a: assert property (@(posedge clk) disable iff (rst)
      res_valid && res.is_mem && !$past(st_ff == ST_ADD2) |->
      res.linear == res.offset + $past(seg_of(req)))
      else $error("linear address wrong");

   // Linear address on the two-step path uses the held request
   two_lin_a: assert property (@(posedge clk) disable iff (rst)
      res_valid && $past(st_ff == ST_ADD2) |->
      res.linear == res.offset + $past(seg_of(hold_ff)))
      else $error("two step linear address wrong");

   // Real mode base is the selector moved up four bits
   real_lin_a: assert property (@(posedge clk) disable iff (rst)
      take && !two_step && nxt_mem && req.real_mode |=>
      res.linear == res.offset + {12'h000, $past(req.selector), 4'h0})
      else $error("real mode linear address wrong");

   // Stack pointer as index adds nothing to the offset
   no_sp_a: assert property (@(posedge clk) disable iff (rst)
      take && req.index_sel == `EAG_SP_IDX &&
      req.mode inside {EAG_INDEX, EAG_SC_INDEX} |=>
      res.offset == $past(disp_x))
      else $error("stack pointer used as index");

   // The refused index selection is reported
   sp_err_a: assert property (@(posedge clk) disable iff (rst)
      take && req.index_sel == `EAG_SP_IDX &&
      req.mode inside {EAG_INDEX, EAG_SC_INDEX} |=> index_err)
      else $error("stack pointer index not flagged");

   // No error pulse without an accepted request
   err_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !take |=> !index_err)
      else $error("index error without request");

   // Byte register operand is zero-extended
   reg_op_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_REG && req.width == EAG_W8 |=>
      res.operand == {24'h00_0000, $past(base_v[7:0])})
      else $error("byte register operand wrong");

   // Immediate never touches memory and keeps its low byte
   imm_op_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode == EAG_IMM |=>
      !res.is_mem && res.operand[7:0] == $past(req.imm[7:0]))
      else $error("immediate operand wrong");

   // Non-memory modes leave the offset clear
   nonmem_off_a: assert property (@(posedge clk) disable iff (rst)
      take && req.mode inside {EAG_REG, EAG_IMM} |=>
      !res.is_mem && res.offset == 32'h0000_0000)
      else $error("non-memory mode produced an offset");

   // Main scenarios worth seeing at least once
   c_both: cover property (@(posedge clk) take && two_step);
   c_scaled: cover property (@(posedge clk) take && use_scale);
   c_reg: cover property (@(posedge clk) take && req.mode == EAG_REG);
   c_real: cover property (@(posedge clk) take && req.real_mode);
   c_sp_index: cover property (@(posedge clk)
      take && req.index_sel == `EAG_SP_IDX);
endmodule // eag_top

// File: sim/eag_gpr_model.sv
// Register file model feeding the address generator
`timescale 1ns/1ps
module eag_gpr_model #(
   parameter int NUM_REGS = 8
) (
   output logic [NUM_REGS*32-1:0] gpr_flat
);
   // Fixed pattern; top register sits just below the wrap point
   always_comb begin
      for (int n = 0; n < NUM_REGS; n++) begin
         gpr_flat[n*32+:32] = (n == NUM_REGS - 1) ? 32'hFFFF_FFF0 :
            32'(32'h1111_1111 * (n + 1));
      end
   end
endmodule // eag_gpr_model

// File: sim/testbench.sv
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module testbench import eag_pkg::*; ;
   logic clk, rst, req_valid, req_ready, res_valid, index_err, err_seen;
   eag_req_t req;
   eag_res_t res;
   logic [255:0] gpr_flat;
   int error_cnt, comparisons;

   eag_top DUT (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .gpr_flat(gpr_flat),
      .res_valid(res_valid), .res(res), .index_err(index_err));
   eag_gpr_model u_gpr (.gpr_flat(gpr_flat));

   // Mirror of the register file pattern
   function automatic logic [31:0] gpr(input int n);
      return n == 7 ? 32'hFFFF_FFF0 : 32'(32'h1111_1111 * (n + 1));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("%0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One request, waits for the result under a bounded count
   task automatic run(input eag_req_t r, input logic [31:0] e, input int lat);
      int n;
      logic mem;
      logic [31:0] lin;
      mem = r.mode != EAG_REG && r.mode != EAG_IMM;
      lin = e + (r.real_mode ? {12'h000, r.selector, 4'h0} : r.seg_base);
      req = r;
      req_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      check({31'h0, req_ready}, {31'h0, lat == 1});
      n = 1;
      err_seen = index_err;
      while (res_valid !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
         err_seen |= index_err;
      end
      check(32'(n), 32'(lat));
      check({31'h0, res.is_mem}, {31'h0, mem});
      if (mem) begin
         check(res.offset, e);
         check(res.linear, lin);
      end else begin
         check(res.operand, e);
      end
      @(negedge clk);
   endtask

   task automatic t_nonmem;
      eag_req_t r;
      r = '0;
      r.base_sel = 3'h7;
      r.width = EAG_W8;
      run(r, 32'h0000_00F0, 1);
      r.width = EAG_W16;
      run(r, 32'h0000_FFF0, 1);
      r.width = EAG_W32;
      run(r, 32'hFFFF_FFF0, 1);
      r.mode = EAG_IMM;
      r.imm = 32'h1234_8765;
      run(r, 32'h1234_8765, 1);
      r.width = EAG_W16;
      run(r, 32'h0000_8765, 1);
      $display("t_nonmem done");
   endtask

   task automatic t_mem_modes;
      eag_req_t r;
      logic [31:0] b, i, s, d, e;
      b = gpr(1);
      i = gpr(2);
      s = i << 2;
      d = 32'h0000_1234;
      for (int k = 2; k < 11; k++) begin
         r = '0;
         r.mode = eag_mode_t'(k);
         r.base_sel = 3'h1;
         r.index_sel = 3'h2;
         r.scale = 2'h2;
         r.dsz = EAG_D32;
         r.disp = d;
         r.seg_base = 32'h0004_0000;
         case (r.mode)
            EAG_DIRECT: e = d;
            EAG_REG_IND: e = b;
            EAG_BASED: e = b + d;
            EAG_INDEX: e = i + d;
            EAG_SC_INDEX: e = s + d;
            EAG_B_INDEX: e = b + i;
            EAG_B_SC_INDEX: e = b + s;
            EAG_B_INDEX_D: e = b + i + d;
            default: e = b + s + d;
         endcase
         run(r, e, k > 6 ? 2 : 1);
      end
      $display("t_mem_modes done");
   endtask

   task automatic t_disp;
      eag_req_t r;
      r = '0;
      r.mode = EAG_BASED;
      r.base_sel = 3'h7;
      r.dsz = EAG_D8;
      r.disp = 32'h0000_0080;
      run(r, 32'hFFFF_FF70, 1);
      r.mode = EAG_DIRECT;
      r.dsz = EAG_D16;
      r.disp = 32'h0000_8000;
      run(r, 32'hFFFF_8000, 1);
      r.mode = EAG_BASED;
      r.base_sel = 3'h4;
      r.dsz = EAG_D0;
      r.selector = 16'hABCD;
      r.real_mode = 1'b1;
      run(r, gpr(4), 1);
      $display("t_disp done");
   endtask

   task automatic t_sp_index;
      eag_req_t r;
      r = '0;
      r.mode = EAG_SC_INDEX;
      r.index_sel = 3'h4;
      r.scale = 2'h3;
      r.dsz = EAG_D32;
      r.disp = 32'h0000_0010;
      run(r, 32'h0000_0010, 1);
      check({31'h0, err_seen}, 32'h1);
      r.index_sel = 3'h3;
      run(r, 32'h0000_0010 + (gpr(3) << 3), 1);
      check({31'h0, err_seen}, 32'h0);
      $display("t_sp_index done");
   endtask

   // Two single-cycle requests with no gap between them
   task automatic t_b2b;
      req = '0;
      req.mode = EAG_REG_IND;
      req.base_sel = 3'h5;
      req_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      check(res.offset, gpr(5));
      req.base_sel = 3'h6;
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      check({31'h0, res_valid}, 32'h1);
      check(res.offset, gpr(6));
      @(negedge clk);
      $display("t_b2b done");
   endtask

   // Free-running core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      err_seen = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_nonmem;
      t_mem_modes;
      t_disp;
      t_sp_index;
      t_b2b;
      summarize;
   end

   // Watchdog, far beyond the few dozen cycles the tests need
   initial begin
      repeat (1000) @(posedge clk);
      error_cnt++;
      summarize;
   end
endmodule // testbench
